// file: logic/rsq_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// (RQ1) Device reset is asynchronous, initializes everything
// (RQ2) Standard part: hold reset at least 100 ns
// (RQ3) Standard part usable right after release
// (RQ4) Standard part: reset polarity is selectable
// (RQ5) Low-voltage part: hold reset at least 500 ns
// (RQ6) Low-voltage part: wait 500 ns after release
// (RQ7) Low-voltage part: active-low reset only
// (RQ8) No access before device leaves reset
// (RQ9) Device floats or parks pins during reset
// (RQ10) Pins follow normal function after reset
// (RQ11) Internal selects held inactive during reset
// (RQ12) Reset clears all port-space registers
// (RQ13) Drive both resets actively, not RC
// (RQ14) Build parameter picks standard or low-voltage
// (RQ15) Chip-select input high enters power-down
module rsq_ctrl #(
	parameter bit LOW_VOLTAGE = 1'b0
) (
	input  wire logic                           mclk_i,
	input  wire logic                           srst_i,
	// Register port
	input  wire logic [rsq_pkg::ADDR_W-1:0]     addr_i,
	input  wire logic [rsq_pkg::DATA_W-1:0]     wdata_i,
	input  wire logic                           wr_i,
	input  wire logic                           rd_i,
	output logic      [rsq_pkg::DATA_W-1:0]     rdata_o,
	// User access gate
	input  wire logic                           access_req_i,
	output logic                                access_grant_o,
	output logic                                ready_o,
	// Device pins
	input  wire logic [rsq_pkg::SEL_W-1:0]      decoder_select_outputs_i,
	output logic                                dev_reset_o,
	output logic                                dev_csi_o
);

	// Variant-dependent timing
	localparam int MIN_CYC = LOW_VOLTAGE ? rsq_pkg::RST_MIN_LV_CYC
	                                     : rsq_pkg::RST_MIN_STD_CYC; // RQ14
	localparam logic [rsq_pkg::CNT_W-1:0] MIN_CNT = MIN_CYC[rsq_pkg::CNT_W-1:0];
	localparam logic [rsq_pkg::CNT_W-1:0] REC_CNT =
		rsq_pkg::RECOVER_LV_CYC[rsq_pkg::CNT_W-1:0];

	// Registers
	rsq_pkg::rsq_state_t               state_reg;
	rsq_pkg::rsq_state_t               state_next;
	logic [4:0]                        ctrl_reg;
	logic [4:0]                        ctrl_next;
	logic [rsq_pkg::EXTRA_W-1:0]       extra_reg;
	logic [rsq_pkg::EXTRA_W-1:0]       extra_next;
	logic [rsq_pkg::REFUSE_W-1:0]      refuse_reg;
	logic [rsq_pkg::REFUSE_W-1:0]      refuse_next;
	logic                              pol_reg;
	logic                              pol_next;
	logic                              sel_err_reg;
	logic                              sel_err_next;
	logic [rsq_pkg::SEL_W-1:0]         sel_meta_reg;
	logic [rsq_pkg::SEL_W-1:0]         sel_sync_reg;
	logic                              dev_reset_reg;
	logic                              dev_reset_next;
	logic                              csi_reg;
	logic                              ready_reg;
	logic                              grant_reg;
	logic [rsq_pkg::DATA_W-1:0]        rdata_reg;
	logic [rsq_pkg::DATA_W-1:0]        rdata_next;

	// Decode and timer wires
	logic                              wr_ctrl;
	logic                              wr_stat;
	logic                              wr_extra;
	logic                              wr_refuse;
	logic                              go_cmd;
	logic                              hold;
	logic                              timer_load;
	logic [rsq_pkg::CNT_W-1:0]         timer_value;
	logic                              timer_busy;
	logic                              in_reset;
	logic                              refused;
	logic                              sel_bad;
	logic [5:0]                        stat_word;

	// Address decode
	assign wr_ctrl   = wr_i && (addr_i == rsq_pkg::OFS_CTRL);
	assign wr_stat   = wr_i && (addr_i == rsq_pkg::OFS_STAT);
	assign wr_extra  = wr_i && (addr_i == rsq_pkg::OFS_EXTRA);
	assign wr_refuse = wr_i && (addr_i == rsq_pkg::OFS_REFUSE);
	assign go_cmd    = wr_ctrl && wdata_i[rsq_pkg::CTRL_GO];
	assign hold      = ctrl_reg[rsq_pkg::CTRL_HOLD];

	// Go bit is a command and never stored
	assign ctrl_next = wr_ctrl ? {wdata_i[4:1], 1'b0} : ctrl_reg;
	assign extra_next = wr_extra ? wdata_i[rsq_pkg::EXTRA_W-1:0] : extra_reg;

	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rsq_pkg::RSQ_LOAD: begin
				state_next = rsq_pkg::RSQ_ASSERT;
			end
			rsq_pkg::RSQ_ASSERT: begin
				// Hold bit stretches the pulse without limit
				if (!timer_busy && !hold) begin
					state_next = LOW_VOLTAGE ? rsq_pkg::RSQ_RECOVER
					                         : rsq_pkg::RSQ_READY; // RQ3 RQ6
				end
			end
			rsq_pkg::RSQ_RECOVER: begin
				if (!timer_busy) begin
					state_next = rsq_pkg::RSQ_READY; // RQ6 RQ10
				end
			end
			rsq_pkg::RSQ_READY: begin
				if (ctrl_reg[rsq_pkg::CTRL_PDOWN]) begin
					state_next = rsq_pkg::RSQ_PDOWN; // RQ15
				end
			end
			rsq_pkg::RSQ_PDOWN: begin
				if (!ctrl_reg[rsq_pkg::CTRL_PDOWN]) begin
					state_next = rsq_pkg::RSQ_READY; // RQ15
				end
			end
			default: begin
				state_next = rsq_pkg::RSQ_LOAD;
			end
		endcase
		// A new pulse may be started from any state
		if (go_cmd) begin
			state_next = rsq_pkg::RSQ_LOAD;
		end
	end

	// Timer loads: pulse length in LOAD, recovery on leaving ASSERT
	assign timer_load  = (state_reg == rsq_pkg::RSQ_LOAD) ||
	                     ((state_reg == rsq_pkg::RSQ_ASSERT) &&
	                      (state_next == rsq_pkg::RSQ_RECOVER));
	assign timer_value = (state_reg == rsq_pkg::RSQ_LOAD)
	                     ? MIN_CNT + {2'b00, extra_reg} // RQ2 RQ5
	                     : REC_CNT; // RQ6

	rsq_timer u_timer (
		.mclk_i  (mclk_i),
		.srst_i  (srst_i),
		.load_i  (timer_load),
		.value_i (timer_value),
		.busy_o  (timer_busy)
	);

	// Polarity is latched only as a pulse starts, so a change never glitches the pin
	assign pol_next = (state_next == rsq_pkg::RSQ_LOAD)
	                  ? (LOW_VOLTAGE ? 1'b0 : ctrl_next[rsq_pkg::CTRL_POL_HI]) // RQ4 RQ7
	                  : pol_reg;

	// Reset pin level: asserted level equals the polarity bit
	assign in_reset = (state_next == rsq_pkg::RSQ_LOAD) ||
	                  (state_next == rsq_pkg::RSQ_ASSERT);
	assign dev_reset_next = in_reset ? pol_next : ~pol_next; // RQ1 RQ13

	// Accesses while the device is not usable are refused and counted
	assign refused = access_req_i && (state_reg != rsq_pkg::RSQ_READY); // RQ8
	assign refuse_next = wr_refuse ? '0 :
	                     (refused && (refuse_reg != rsq_pkg::REFUSE_MAX))
	                     ? refuse_reg + 1'b1 : refuse_reg;

	// Standard part parks CMOS selects high near the end of the pulse;
	// only checked there so the synchroniser has settled
	assign sel_bad = !LOW_VOLTAGE && ctrl_reg[rsq_pkg::CTRL_CHK_EN] &&
	                 (state_reg == rsq_pkg::RSQ_ASSERT) && !timer_busy &&
	                 (sel_sync_reg != rsq_pkg::SEL_ALL_HI); // RQ9 RQ11
	// Set wins over a write-one clear
	assign sel_err_next = sel_bad ||
	                      (sel_err_reg && !(wr_stat && wdata_i[rsq_pkg::STAT_SEL_ERR]));

	// Status word
	assign stat_word = {LOW_VOLTAGE,
	                    sel_err_reg,
	                    state_reg == rsq_pkg::RSQ_PDOWN,
	                    state_reg == rsq_pkg::RSQ_READY,
	                    state_reg == rsq_pkg::RSQ_RECOVER,
	                    (state_reg == rsq_pkg::RSQ_LOAD) || (state_reg == rsq_pkg::RSQ_ASSERT)};

	// Read mux, unmapped offsets read zero
	always_comb begin
		rdata_next = '0;
		if (rd_i) begin
			case (addr_i)
				rsq_pkg::OFS_CTRL:   rdata_next[4:0] = ctrl_reg;
				rsq_pkg::OFS_STAT:   rdata_next[5:0] = stat_word;
				rsq_pkg::OFS_EXTRA:  rdata_next[rsq_pkg::EXTRA_W-1:0] = extra_reg;
				rsq_pkg::OFS_REFUSE: rdata_next[rsq_pkg::REFUSE_W-1:0] = refuse_reg;
				rsq_pkg::OFS_SELS:   rdata_next[rsq_pkg::SEL_W-1:0] = sel_sync_reg;
				default:             rdata_next = '0;
			endcase
		end
	end

	// Sequencer and pin state; srst starts a device reset pulse
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state_reg     <= rsq_pkg::RSQ_LOAD;
			pol_reg       <= 1'b0;
			dev_reset_reg <= 1'b0;
			csi_reg       <= 1'b0;
			ready_reg     <= 1'b0;
			grant_reg     <= 1'b0;
		end else begin
			state_reg     <= state_next;
			pol_reg       <= pol_next;
			dev_reset_reg <= dev_reset_next;
			csi_reg       <= (state_next == rsq_pkg::RSQ_PDOWN); // RQ15
			ready_reg     <= (state_next == rsq_pkg::RSQ_READY); // RQ8 RQ10
			grant_reg     <= access_req_i && (state_reg == rsq_pkg::RSQ_READY); // RQ8
		end
	end

	// Software-visible registers
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ctrl_reg    <= rsq_pkg::CTRL_RST;
			extra_reg   <= rsq_pkg::EXTRA_RST;
			refuse_reg  <= '0;
			sel_err_reg <= 1'b0;
			rdata_reg   <= '0;
		end else begin
			ctrl_reg    <= ctrl_next;
			extra_reg   <= extra_next;
			refuse_reg  <= refuse_next;
			sel_err_reg <= sel_err_next;
			rdata_reg   <= rdata_next;
		end
	end

	// Two-flop synchroniser for the device select pins
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sel_meta_reg <= '0;
			sel_sync_reg <= '0;
		end else begin
			sel_meta_reg <= decoder_select_outputs_i;
			sel_sync_reg <= sel_meta_reg;
		end
	end

	assign rdata_o        = rdata_reg;
	assign access_grant_o = grant_reg;
	assign ready_o        = ready_reg;
	assign dev_reset_o    = dev_reset_reg;
	assign dev_csi_o      = csi_reg;

endmodule // rsq_ctrl

// file: logic/rsq_pkg.sv
package rsq_pkg;

	// Clock and timing figures, times in ns
	localparam int CLK_PERIOD_NS   = 5;
	localparam int RST_MIN_STD_NS  = 100;
	localparam int RST_MIN_LV_NS   = 500;
	localparam int RECOVER_LV_NS   = 500;

	// Least times round up to whole cycles
	localparam int RST_MIN_STD_CYC = (RST_MIN_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_MIN_LV_CYC  = (RST_MIN_LV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_LV_CYC  = (RECOVER_LV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Widths
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int CNT_W    = 10;
	localparam int EXTRA_W  = 8;
	localparam int REFUSE_W = 16;
	localparam int SEL_W    = 11;

	// Register offsets, byte addresses
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STAT   = 8'h04;
	localparam logic [7:0] OFS_EXTRA  = 8'h08;
	localparam logic [7:0] OFS_REFUSE = 8'h0c;
	localparam logic [7:0] OFS_SELS   = 8'h10;

	// Control register fields
	localparam int CTRL_GO      = 0;
	localparam int CTRL_POL_HI  = 1;
	localparam int CTRL_PDOWN   = 2;
	localparam int CTRL_HOLD    = 3;
	localparam int CTRL_CHK_EN  = 4;

	// Status register fields
	localparam int STAT_IN_RST  = 0;
	localparam int STAT_RECOV   = 1;
	localparam int STAT_READY   = 2;
	localparam int STAT_PDOWN   = 3;
	localparam int STAT_SEL_ERR = 4;
	localparam int STAT_LV      = 5;

	// Reset values, refusal count limit and parked select level
	localparam logic [4:0]          CTRL_RST   = 5'h00;
	localparam logic [EXTRA_W-1:0]  EXTRA_RST  = 8'h00;
	localparam logic [REFUSE_W-1:0] REFUSE_MAX = 16'hffff;
	localparam logic [SEL_W-1:0]    SEL_ALL_HI = 11'h7ff;

	// Sequencer states
	typedef enum logic [2:0] {
		RSQ_LOAD,
		RSQ_ASSERT,
		RSQ_RECOVER,
		RSQ_READY,
		RSQ_PDOWN
	} rsq_state_t;

endpackage

// file: logic/rsq_timer.sv
`timescale 1ns/100ps
// Down-counter for assertion and recovery intervals
module rsq_timer (
	input  wire logic                       mclk_i,
	input  wire logic                       srst_i,
	input  wire logic                       load_i,
	input  wire logic [rsq_pkg::CNT_W-1:0]  value_i,
	output logic                            busy_o
);

	logic [rsq_pkg::CNT_W-1:0] cnt_reg;
	logic [rsq_pkg::CNT_W-1:0] cnt_next;

	// Load wins over the running count
	assign cnt_next = load_i ? value_i :
	                  (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Busy while any cycles remain
	assign busy_o = (cnt_reg != '0);

endmodule // rsq_timer

// file: verif/rsq_ctrl_assertions.sv
`timescale 1ns/100ps
// Watches the reset pin, power-down pin and register port of one controller
module rsq_ctrl_chk #(
	parameter bit LOW_VOLTAGE = 1'b0
) (
	input wire logic	mclk_i,
	input wire logic	srst_i,
	input wire logic [7:0]	addr_i,
	input wire logic [31:0]	wdata_i,
	input wire logic	wr_i,
	input wire logic	rd_i,
	input wire logic [31:0]	rdata_o,
	input wire logic	access_req_i,
	input wire logic	access_grant_o,
	input wire logic	ready_o,
	input wire logic [10:0]	decoder_select_outputs_i,
	input wire logic	dev_reset_o,
	input wire logic	dev_csi_o
);
	localparam int MINC = LOW_VOLTAGE ? rsq_pkg::RST_MIN_LV_CYC : rsq_pkg::RST_MIN_STD_CYC;
	logic	lvl_reg;
	logic [9:0]	hc_reg;
	wire	ctl_wr = wr_i && addr_i == rsq_pkg::OFS_CTRL;
	wire	go = ctl_wr && wdata_i[rsq_pkg::CTRL_GO];
	wire	asrt = dev_reset_o == lvl_reg;
	// Asserted level latched per pulse, as polarity may change between pulses
	always_ff @(posedge mclk_i)
		if (srst_i) lvl_reg <= 1'b0;
		else if (go) lvl_reg <= wdata_i[rsq_pkg::CTRL_POL_HI] && !LOW_VOLTAGE;
	// Length of the current asserted run
	always_ff @(posedge mclk_i) hc_reg <= (srst_i || !asrt) ? 10'h0 : hc_reg + 10'h1;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	chk_go_starts: assert property (go |=> asrt && !ready_o)
		else $error("no pulse after go");
	chk_pulse_level: assert property (go && LOW_VOLTAGE |=> !dev_reset_o)
		else $error("low-voltage pulse not low");
	chk_min_pulse: assert property ($fell(asrt) |-> hc_reg > MINC)
		else $error("reset pulse too short");
	chk_std_ready: assert property ($fell(asrt) |-> ready_o == !LOW_VOLTAGE)
		else $error("ready wrong at release");
	chk_lv_recover: assert property (LOW_VOLTAGE && $fell(asrt) |-> ##100 !ready_o ##1 ready_o)
		else $error("recovery span wrong");
	chk_rst_idle: assert property (asrt |-> !ready_o)
		else $error("ready during reset");
	chk_grant_cause: assert property (access_grant_o |-> $past(access_req_i && ready_o))
		else $error("grant without ready request");
	chk_pdown_entry: assert property (ctl_wr && wdata_i[rsq_pkg::CTRL_PDOWN] &&
		!wdata_i[rsq_pkg::CTRL_GO] && ready_o |-> ##[1:3] dev_csi_o && !ready_o)
		else $error("power-down not entered");
endmodule // rsq_ctrl_chk

bind rsq_ctrl rsq_ctrl_chk #(.LOW_VOLTAGE(LOW_VOLTAGE)) rsq_ctrl_chk_inst (.*);

// file: verif/rsq_dev_model.sv
`timescale 1ns/100ps
// Behavioural device: reset pin, power-down input and select outputs
module rsq_dev_model #(
	parameter bit LV = 1'b0
) (
	input  wire logic	dev_reset_i,
	input  wire logic	dev_csi_i,
	input  wire logic	pol_hi_i,
	input  wire logic [10:0]	eqn_i,
	output logic [10:0]	sel_o
);
	logic	live;
	logic [10:0]	flt = 11'h2aa;
	logic [7:0]	port_regs;
	// Low-voltage part ignores the configured level
	wire in_rst = LV ? !dev_reset_i : dev_reset_i == pol_hi_i;
	// Undriven lines never hold their last value
	always #5 flt = ~flt;
	// No clock; low-voltage part stays dead for 500 ns after release
	always @(in_rst) begin
		live = 1'b0;
		port_regs = 8'h00;
		if (!in_rst) #(LV ? 500 : 0) live = !in_rst;
	end
	// Standard selects park high, low-voltage ones float
	assign sel_o = (!live && LV) ? flt : (!live || dev_csi_i) ? 11'h7ff : eqn_i;
endmodule // rsq_dev_model

// file: verif/tb.sv
`timescale 1ns/100ps
// Standard and low-voltage controllers share one register port
module tb;
	localparam logic [10:0] EQN = 11'h5a3;
	localparam int MINC [2] = '{rsq_pkg::RST_MIN_STD_CYC, rsq_pkg::RST_MIN_LV_CYC};
	// Recovery runs one cycle past its count, as the timer idles at zero once
	localparam int REC [2] = '{0, rsq_pkg::RECOVER_LV_CYC + 1};
	logic	mclk_i = 1'b0;
	logic	srst_i = 1'b1;
	logic [7:0]	addr_i = 8'h00;
	logic [31:0]	wdata_i = 32'h0;
	logic	wr_i = 1'b0;
	logic	rd_i = 1'b0;
	logic	access_req_i = 1'b0;
	logic	pol = 1'b0;
	logic [31:0]	rdata [2];
	logic [10:0]	sel [2];
	logic	grant [2];
	logic	ready [2];
	logic	drst [2];
	logic	csi [2];
	int	rc [2];
	int	wc [2];
	int	bad_count = 0;
	int	n_compared = 0;
	wire	go = wr_i && addr_i == rsq_pkg::OFS_CTRL;

	// 200 MHz
	always #2.5 mclk_i = ~mclk_i;

	for (genvar g = 0; g < 2; g++) begin : u
		rsq_ctrl #(.LOW_VOLTAGE(g == 1)) rsq_ctrl_inst (.mclk_i(mclk_i), .srst_i(srst_i),
			.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata[g]),
			.access_req_i(access_req_i), .access_grant_o(grant[g]), .ready_o(ready[g]),
			.decoder_select_outputs_i(sel[g]), .dev_reset_o(drst[g]), .dev_csi_o(csi[g]));
		rsq_dev_model #(.LV(g == 1)) rsq_dev_model_inst (.dev_reset_i(drst[g]),
			.dev_csi_i(csi[g]), .pol_hi_i(pol), .eqn_i(EQN), .sel_o(sel[g]));
		// Asserted and not-ready spans, restarted by each control write
		always @(posedge mclk_i) begin
			rc[g] <= go ? 0 : rc[g] + (drst[g] === (pol && g == 0));
			wc[g] <= go ? 0 : wc[g] + (ready[g] !== 1'b1);
		end
	end

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		// Idle edge, so a following write never reassigns the strobe in one step
		@(posedge mclk_i);
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e0, e1, input logic [1:0] m = 2'b11);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(posedge mclk_i);
		if (m[0]) cmp("rdata_std", e0, rdata[0]);
		if (m[1]) cmp("rdata_lv", e1, rdata[1]);
	endtask

	task automatic wait_rdy;
		int i;
		for (i = 0; i < 400 && !(ready[0] === 1'b1 && ready[1] === 1'b1); i++) @(posedge mclk_i);
		cmp("ready_wait", 1, i < 400);
	endtask

	// Pulse with refused requests during it, then timing and pin checks
	task automatic pulse(input logic p, input logic [7:0] x);
		wr(rsq_pkg::OFS_EXTRA, {24'h0, x});
		wr(rsq_pkg::OFS_REFUSE, 0);
		pol <= p;
		// Select check on, so a false select error would show in status
		wr(rsq_pkg::OFS_CTRL, {27'h0, 1'b1, 2'b00, p, 1'b1});
		@(posedge mclk_i);
		access_req_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		access_req_i <= 1'b0;
		rd(rsq_pkg::OFS_SELS, 32'h7ff, 0, 2'b01);
		wait_rdy();
		@(posedge mclk_i);
		for (int g = 0; g < 2; g++) begin
			// Load cycle and the timer's zero cycle each add one
			cmp("pulse_len", MINC[g] + x + 2, rc[g]);
			cmp("not_ready", MINC[g] + x + 2 + REC[g], wc[g]);
			cmp("idle_level", !(p && g == 0), drst[g]);
		end
		rd(rsq_pkg::OFS_REFUSE, 3, 3);
		rd(rsq_pkg::OFS_SELS, EQN, EQN);
		rd(rsq_pkg::OFS_STAT, 32'h4, 32'h24);
		$display("test pulse pol %0d extra %0d done", p, x);
	endtask

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
		rd(rsq_pkg::OFS_CTRL, 0, 0);
		rd(8'h14, 0, 0);
		rd(rsq_pkg::OFS_STAT, 32'h1, 32'h21);
		wait_rdy();
		$display("test reset values done");
		pulse(1'b0, 8'h00);
		access_req_i <= 1'b1;
		@(posedge mclk_i);
		access_req_i <= 1'b0;
		@(posedge mclk_i);
		cmp("grant", 3, {grant[1], grant[0]});
		pulse(1'b1, 8'h03);
		rd(rsq_pkg::OFS_STAT, 32'h4, 32'h24);
		wr(rsq_pkg::OFS_CTRL, 32'h4);
		repeat (8) @(posedge mclk_i);
		cmp("pdown", 32'h3, {ready[1], ready[0], csi[1], csi[0]});
		rd(rsq_pkg::OFS_SELS, 32'h7ff, 32'h7ff);
		wr(rsq_pkg::OFS_CTRL, 32'h0);
		wait_rdy();
		cmp("wake", 0, {csi[1], csi[0]});
		$display("test power-down done");
		// Hold bit keeps both parts in reset well past either minimum
		pol <= 1'b0;
		wr(rsq_pkg::OFS_CTRL, 32'h9);
		repeat (150) @(posedge mclk_i);
		rd(rsq_pkg::OFS_STAT, 32'h1, 32'h21);
		for (int g = 0; g < 2; g++) begin
			cmp("hold_len", 152, rc[g]);
		end
		wr(rsq_pkg::OFS_CTRL, 32'h0);
		wait_rdy();
		cmp("hold_idle", 32'h3, {drst[1], drst[0]});
		$display("test hold done");
		stop_test();
	end

	// Whole run needs under 1000 cycles; four times that is a hang
	initial begin
		#20000;
		bad_count++;
		stop_test();
	end
endmodule // tb
